// ### hw/csg_clk_div.sv
module csg_clk_div (
	input  wire logic           CLK_IN,
	input  wire logic           SYS_RST_IN,
	input  wire logic [3:0]     TICK_IN,
	input  wire csg_pkg::csg_src_t SRC_IN,
	input  wire logic [1:0]     DIV_IN,
	output logic                EN_OUT
);
	import csg_pkg::*;

	typedef struct packed {
		csg_src_t   src;
		logic [1:0] div;
		logic [2:0] cnt;
		logic       en;
	} csg_div_state_t;

	csg_div_state_t s_reg;
	csg_div_state_t s_next;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	always_comb begin
		s_next     = s_reg;
		s_next.src = SRC_IN;
		s_next.div = DIV_IN;
		s_next.en  = 1'b0;
		if (SRC_IN != s_reg.src || DIV_IN != s_reg.div) begin
			s_next.cnt = 3'h0;
		end else if (TICK_IN[s_reg.src]) begin
			if (s_reg.cnt == 3'((4'h1 << s_reg.div) - 4'h1)) begin
				s_next.cnt = 3'h0;
				s_next.en  = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt + 3'h1;
			end
		end
		if (SYS_RST_IN) begin
			s_next     = '0;
			s_next.src = SRC_FAST;
			s_next.div = DIV_RST;
		end
	end

	always_ff @(posedge CLK_IN) begin
		s_reg <= s_next;
	end

	assign EN_OUT = s_reg.en;

endmodule // csg_clk_div

// ### hw/csg_pkg.sv
package csg_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 250;
	localparam int CLK_HZ           = 250_000_000;
	localparam int LP_INT_HZ        = 32_768;
	localparam int LP_INT_DIV_CYC   = CLK_HZ / LP_INT_HZ;
	localparam int LP_STOP_PERIODS  = 4;
	localparam int LP_STOP_CYC      = (CLK_HZ / LP_INT_HZ) * LP_STOP_PERIODS;
	localparam int LP_WAIT_BASE_TCK = 4_096;
	localparam int HS_WAIT_BASE_TCK = 128;
	localparam logic [19:0] FAST_WAIT_TCK = 20'h0_0010;
	localparam logic [7:0]  BOOST_TCK     = 8'h40;

	// Fast oscillator frequencies in MHz
	localparam int FAST_F0_MHZ = 20;
	localparam int FAST_F1_MHZ = 16;
	localparam int FAST_F2_MHZ = 12;
	localparam int FAST_F3_MHZ = 8;
	localparam int FAST_F4_MHZ = 2;
	localparam int FAST_F5_MHZ = 1;

	// ----------------------------------------
	// Sources
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRC_FAST = 2'b00,
		SRC_LP   = 2'b01,
		SRC_HS   = 2'b10,
		SRC_EXT  = 2'b11
	} csg_src_t;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_SRC_EN   = 8'h00;
	localparam logic [7:0] OFS_FAST_CFG = 8'h04;
	localparam logic [7:0] OFS_SYS_CLK  = 8'h08;
	localparam logic [7:0] OFS_PER_CLK  = 8'h0C;
	localparam logic [7:0] OFS_SLEEP    = 8'h10;
	localparam logic [7:0] OFS_WAIT     = 8'h14;
	localparam logic [7:0] OFS_CLK_OUT  = 8'h18;
	localparam logic [7:0] OFS_STATUS   = 8'h1C;
	localparam logic [7:0] OFS_INT_STAT = 8'h20;
	localparam logic [7:0] OFS_INT_CLR  = 8'h24;
	localparam logic [7:0] OFS_INT_EN   = 8'h28;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0] SRC_EN_RST   = 4'h1;
	localparam logic [2:0] FAST_SEL_RST = 3'h3;
	localparam logic [1:0] DIV_RST      = 2'h0;

	// Cycles of CLK_IN per fast oscillator period
	function automatic logic [7:0] fast_period(input logic [2:0] sel);
		unique case (sel)
			3'h0: fast_period = 8'(CLK_MHZ / FAST_F0_MHZ);
			3'h1: fast_period = 8'(CLK_MHZ / FAST_F1_MHZ);
			3'h2: fast_period = 8'(CLK_MHZ / FAST_F2_MHZ);
			3'h4: fast_period = 8'(CLK_MHZ / FAST_F4_MHZ);
			3'h5: fast_period = 8'(CLK_MHZ / FAST_F5_MHZ);
			default: fast_period = 8'(CLK_MHZ / FAST_F3_MHZ);
		endcase
	endfunction

endpackage : csg_pkg

// ### hw/csg_top.sv
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
module csg_top #(
	parameter int LP_INT_DIV   = csg_pkg::LP_INT_DIV_CYC,
	parameter int LP_STOP_TO   = csg_pkg::LP_STOP_CYC,
	parameter int LP_WAIT_BASE = csg_pkg::LP_WAIT_BASE_TCK,
	parameter int HS_WAIT_BASE = csg_pkg::HS_WAIT_BASE_TCK
) (
	input  wire logic        CLK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        SLEEP_REQ_IN,
	input  wire logic        LP_XTAL_IN,
	input  wire logic        HS_XTAL_IN,
	input  wire logic        EXT_CLK_IN,
	output logic             FAST_OSC_EN_OUT,
	output logic             LP_OSC_EN_OUT,
	output logic             HS_OSC_EN_OUT,
	output logic             EXT_CLK_EN_OUT,
	output logic             LP_XTAL_SEL_OUT,
	output logic             LP_BOOST_OUT,
	output logic             SYS_CLK_EN_OUT,
	output logic             PER_CLK_EN_OUT,
	output logic             CLK_OUT_PIN_OUT,
	output logic             IRQ_OUT
);
	import csg_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]       sync1;
		logic [2:0]       sync2;
		logic [2:0]       prev;
		logic [7:0]       fast_cnt;
		logic [15:0]      lp_div_cnt;
		logic [3:0]       en;
		logic             lp_xtal;
		logic             boost_en;
		logic [2:0]       fast_sel;
		csg_src_t         sys_src;
		logic [1:0]       sys_div;
		csg_src_t         per_src;
		logic [1:0]       per_div;
		logic [3:0]       stop_mask;
		csg_src_t         wake_src;
		logic             wake_sw;
		logic [3:0]       wake_val;
		logic [3:0]       wake_chg;
		logic [1:0]       lp_wt;
		logic [2:0]       hs_wt;
		logic             clkout_en;
		csg_src_t         clkout_src;
		logic             clkout;
		logic [3:0]       run;
		logic [3:0]       ready;
		logic [2:0][19:0] wcnt;
		logic [19:0]      idle_cnt;
		logic [7:0]       boost_cnt;
		logic             boost;
		logic [4:0]       int_stat;
		logic [4:0]       int_en;
		logic             irq;
		logic             sleep_prev;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} csg_state_t;

	csg_state_t  s_reg;
	csg_state_t  s_next;
	logic [2:0]  pin_edge;
	logic        fast_tick;
	logic        lp_int_tick;
	logic [3:0]  raw_tick;
	logic [3:0]  gated_tick;
	logic [3:0]  run_calc;
	logic [4:0]  evt;
	logic        stop_evt;
	logic        sleep_exit;
	logic        acc_wr;
	logic        acc_rd;
	logic [19:0] target;

	// Mapped register word
	function automatic logic addr_hit(input logic [7:0] a);
		unique case (a)
			OFS_SRC_EN, OFS_FAST_CFG, OFS_SYS_CLK, OFS_PER_CLK, OFS_SLEEP, OFS_WAIT,
			OFS_CLK_OUT, OFS_STATUS, OFS_INT_STAT, OFS_INT_CLR, OFS_INT_EN: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	endfunction

	// Stabilization length in own ticks
	function automatic logic [19:0] wait_len(input int idx, input logic [1:0] lw, input logic [2:0] hw);
		unique case (idx)
			0: wait_len = FAST_WAIT_TCK;
			1: wait_len = 20'(LP_WAIT_BASE) << lw;
			default: wait_len = 20'(HS_WAIT_BASE) << hw;
		endcase
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		target = 20'h0_0000;
		evt    = 5'h00;

		// Pins pass two flops before use
		s_next.sync1 = {EXT_CLK_IN, HS_XTAL_IN, LP_XTAL_IN};
		s_next.sync2 = s_reg.sync1;
		s_next.prev  = s_reg.sync2;
		pin_edge     = s_reg.sync2 & ~s_reg.prev;

		fast_tick = s_reg.run[0] && (s_reg.fast_cnt >= fast_period(s_reg.fast_sel) - 8'h01);
		s_next.fast_cnt = (!s_reg.run[0] || fast_tick) ? 8'h00 : s_reg.fast_cnt + 8'h01;

		lp_int_tick = s_reg.run[1] && !s_reg.lp_xtal && (s_reg.lp_div_cnt >= 16'(LP_INT_DIV - 1));
		s_next.lp_div_cnt = (!s_reg.run[1] || s_reg.lp_xtal || lp_int_tick) ? 16'h0000
			: s_reg.lp_div_cnt + 16'h0001;

		raw_tick[0] = fast_tick;
		raw_tick[1] = s_reg.run[1] && (s_reg.lp_xtal ? pin_edge[0] : lp_int_tick);
		raw_tick[2] = s_reg.run[2] && pin_edge[1];
		raw_tick[3] = s_reg.run[3] && pin_edge[2];
		gated_tick  = raw_tick & s_reg.ready;

		for (int i = 0; i < 3; i++) begin
			target = wait_len(i, s_reg.lp_wt, s_reg.hs_wt);
			if (!s_reg.run[i]) begin
				s_next.wcnt[i]  = 20'h0_0000;
				s_next.ready[i] = 1'b0;
			end else if (!s_reg.ready[i] && raw_tick[i]) begin
				s_next.wcnt[i] = s_reg.wcnt[i] + 20'h0_0001;
				if (s_reg.wcnt[i] + 20'h0_0001 >= target) begin
					s_next.ready[i] = 1'b1;
					evt[i]          = 1'b1;
				end
			end
		end
		s_next.ready[3] = s_reg.run[3];
		evt[3]          = s_reg.run[3] && !s_reg.ready[3];

		stop_evt = 1'b0;
		if (s_reg.run[1] && s_reg.lp_xtal && s_reg.ready[1]) begin
			s_next.idle_cnt = raw_tick[1] ? 20'h0_0000 : s_reg.idle_cnt + 20'h0_0001;
			if (s_reg.idle_cnt == 20'(LP_STOP_TO - 1)) begin
				stop_evt = 1'b1;
			end
		end else begin
			s_next.idle_cnt = 20'h0_0000;
		end
		evt[4] = stop_evt;

		// ----------------------------------------
		// Register bus
		// ----------------------------------------
		// Zero wait after one registered stall cycle
		acc_rd = PSEL_IN && PENABLE_IN && !s_reg.pready;
		acc_wr = PSEL_IN && PENABLE_IN && s_reg.pready && PWRITE_IN && !s_reg.pslverr;
		s_next.pready  = acc_rd;
		s_next.pslverr = acc_rd && !addr_hit(PADDR_IN);
		s_next.prdata  = 32'h0000_0000;
		if (acc_rd && !PWRITE_IN) begin
			unique case (PADDR_IN)
				OFS_SRC_EN:   s_next.prdata = {26'h0, s_reg.boost_en, s_reg.lp_xtal, s_reg.en};
				OFS_FAST_CFG: s_next.prdata = {29'h0, s_reg.fast_sel};
				OFS_SYS_CLK:  s_next.prdata = {28'h0, s_reg.sys_div, s_reg.sys_src};
				OFS_PER_CLK:  s_next.prdata = {28'h0, s_reg.per_div, s_reg.per_src};
				OFS_SLEEP:    s_next.prdata = {16'h0, s_reg.wake_chg, s_reg.wake_val, 1'b0,
					s_reg.wake_sw, s_reg.wake_src, s_reg.stop_mask};
				OFS_WAIT:     s_next.prdata = {25'h0, s_reg.hs_wt, 2'h0, s_reg.lp_wt};
				OFS_CLK_OUT:  s_next.prdata = {29'h0, s_reg.clkout_src, s_reg.clkout_en};
				OFS_STATUS:   s_next.prdata = {22'h0, s_reg.boost, s_reg.sleep_prev, s_reg.run, s_reg.ready};
				OFS_INT_STAT: s_next.prdata = {27'h0, s_reg.int_stat};
				OFS_INT_EN:   s_next.prdata = {27'h0, s_reg.int_en};
				default:      s_next.prdata = 32'h0000_0000;
			endcase
		end
		if (acc_wr) begin
			unique case (PADDR_IN)
				OFS_SRC_EN: begin
					s_next.en       = PWDATA_IN[3:0];
					s_next.lp_xtal  = PWDATA_IN[4];
					s_next.boost_en = PWDATA_IN[5];
				end
				OFS_FAST_CFG: s_next.fast_sel = PWDATA_IN[2:0];
				OFS_SYS_CLK: begin
					s_next.sys_src = csg_src_t'(PWDATA_IN[1:0]);
					s_next.sys_div = PWDATA_IN[3:2];
				end
				OFS_PER_CLK: begin
					s_next.per_src = csg_src_t'(PWDATA_IN[1:0]);
					s_next.per_div = PWDATA_IN[3:2];
				end
				OFS_SLEEP: begin
					s_next.stop_mask = PWDATA_IN[3:0];
					s_next.wake_src  = csg_src_t'(PWDATA_IN[5:4]);
					s_next.wake_sw   = PWDATA_IN[6];
					s_next.wake_val  = PWDATA_IN[11:8];
					s_next.wake_chg  = PWDATA_IN[15:12];
				end
				OFS_WAIT: begin
					s_next.lp_wt = PWDATA_IN[1:0];
					s_next.hs_wt = PWDATA_IN[6:4];
				end
				OFS_CLK_OUT: begin
					s_next.clkout_en  = PWDATA_IN[0];
					s_next.clkout_src = csg_src_t'(PWDATA_IN[2:1]);
				end
				OFS_INT_EN: s_next.int_en = PWDATA_IN[4:0];
				default: ;
			endcase
		end

		// Set wins over a clear in the same cycle
		s_next.int_stat = (s_reg.int_stat & ~((acc_wr && PADDR_IN == OFS_INT_CLR) ? PWDATA_IN[4:0] : 5'h00))
			| evt;
		s_next.irq = |(s_reg.int_stat & s_reg.int_en);

		// ----------------------------------------
		// Sleep control
		// ----------------------------------------
		sleep_exit        = s_reg.sleep_prev && !SLEEP_REQ_IN;
		s_next.sleep_prev = SLEEP_REQ_IN;
		if (sleep_exit) begin
			if (s_reg.wake_sw) begin
				s_next.sys_src = s_reg.wake_src;
			end
			s_next.en = (s_next.en & ~s_reg.wake_chg) | (s_reg.wake_val & s_reg.wake_chg);
		end

		run_calc   = s_reg.en & ~({4{s_reg.sleep_prev}} & s_reg.stop_mask);
		s_next.run = run_calc;
		if (stop_evt) begin
			s_next.run[1] = 1'b0;
		end

		if (!s_reg.run[1] || !s_reg.lp_xtal) begin
			s_next.boost_cnt = 8'h00;
		end else if (!s_reg.ready[1] && s_reg.wcnt[1] == 20'h0_0000 && !raw_tick[1]
			&& s_reg.boost_en && s_reg.lp_xtal && s_reg.boost_cnt == 8'h00 && !s_reg.boost) begin
			s_next.boost_cnt = BOOST_TCK;
		end else if (raw_tick[1] && s_reg.boost_cnt != 8'h00) begin
			s_next.boost_cnt = s_reg.boost_cnt - 8'h01;
		end
		// Assist only drives a crystal; drop it with the mode bit
		s_next.boost = s_next.lp_xtal && (s_next.boost_cnt != 8'h00 || (s_reg.boost && s_reg.run[1]
			&& !s_reg.ready[1] && s_reg.boost_cnt != 8'h00));

		if (!s_reg.clkout_en) begin
			s_next.clkout = 1'b0;
		end else if (gated_tick[s_reg.clkout_src]) begin
			s_next.clkout = !s_reg.clkout;
		end

		if (SYS_RST_IN) begin
			s_next          = '0;
			s_next.en       = SRC_EN_RST;
			s_next.fast_sel = FAST_SEL_RST;
			s_next.sys_src  = SRC_FAST;
			s_next.sys_div  = DIV_RST;
			s_next.per_src  = SRC_FAST;
			s_next.per_div  = DIV_RST;
			s_next.wake_src = SRC_FAST;
			s_next.clkout_src = SRC_FAST;
		end
	end

	always_ff @(posedge CLK_IN) begin
		s_reg <= s_next;
	end

	// ----------------------------------------
	// Clock dividers
	// ----------------------------------------
	csg_clk_div u_sys_div (
		.CLK_IN     (CLK_IN),
		.SYS_RST_IN (SYS_RST_IN),
		.TICK_IN    (gated_tick),
		.SRC_IN     (s_reg.sys_src),
		.DIV_IN     (s_reg.sys_div),
		.EN_OUT     (SYS_CLK_EN_OUT)
	);

	csg_clk_div u_per_div (
		.CLK_IN     (CLK_IN),
		.SYS_RST_IN (SYS_RST_IN),
		.TICK_IN    (gated_tick),
		.SRC_IN     (s_reg.per_src),
		.DIV_IN     (s_reg.per_div),
		.EN_OUT     (PER_CLK_EN_OUT)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign PRDATA_OUT      = s_reg.prdata;
	assign PREADY_OUT      = s_reg.pready;
	assign PSLVERR_OUT     = s_reg.pslverr;
	assign FAST_OSC_EN_OUT = s_reg.run[0];
	assign LP_OSC_EN_OUT   = s_reg.run[1];
	assign HS_OSC_EN_OUT   = s_reg.run[2];
	assign EXT_CLK_EN_OUT  = s_reg.run[3];
	assign LP_XTAL_SEL_OUT = s_reg.lp_xtal;
	assign LP_BOOST_OUT    = s_reg.boost;
	assign CLK_OUT_PIN_OUT = s_reg.clkout;
	assign IRQ_OUT         = s_reg.irq;

endmodule // csg_top

// ### sim/csg_osc_model.sv
module csg_osc_model (
	input  wire logic lp_on_in,
	input  wire logic hs_on_in,
	input  wire logic ext_on_in,
	output logic      lp_wave_out,
	output logic      hs_wave_out,
	output logic      ext_wave_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Resonators and external source
	// ----------------------------------------
	// Odd offset keeps edges off the sampling edge
	// crystal halts when stopped
	initial begin
		lp_wave_out = 1'b0;
		#1;
		forever #16 lp_wave_out = lp_on_in ? ~lp_wave_out : 1'b0;
	end
	initial begin
		hs_wave_out = 1'b0;
		#1;
		forever #6 hs_wave_out = hs_on_in ? ~hs_wave_out : 1'b0;
	end
	initial begin
		ext_wave_out = 1'b0;
		#1;
		forever #20 ext_wave_out = ext_on_in ? ~ext_wave_out : 1'b0;
	end
endmodule // csg_osc_model

// ### sim/csg_top_monitor.sv
module csg_top_monitor (
	input wire logic        CLK_IN,
	input wire logic        SYS_RST_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        FAST_OSC_EN_OUT,
	input wire logic        LP_XTAL_SEL_OUT,
	input wire logic        LP_BOOST_OUT,
	input wire logic        SYS_CLK_EN_OUT,
	input wire logic        CLK_OUT_PIN_OUT,
	input wire logic        IRQ_OUT
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] since_rst;
	// Cycles since reset release, saturating
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			since_rst <= 10'h000;
		end else if (since_rst != 10'h3FF) begin
			since_rst <= since_rst + 10'h001;
		end
	end
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	pready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("pready held too long");
	pready_wait_a: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
		else $error("pready late");
	slverr_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("slverr without pready");
	err_read_zero_a: assert property (PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0000_0000)
		else $error("error read not zero");
	fast_boot_a: assert property ($fell(SYS_RST_IN) |-> ##[0:2] FAST_OSC_EN_OUT)
		else $error("fast source not started");
	sys_tick_gate_a: assert property ($fell(SYS_RST_IN) |-> !SYS_CLK_EN_OUT [*8])
		else $error("tick before ready");
	fast_wait_a: assert property (SYS_CLK_EN_OUT |->
		since_rst >= 10'(csg_pkg::FAST_WAIT_TCK * (csg_pkg::CLK_MHZ / csg_pkg::FAST_F3_MHZ)))
		else $error("tick before fast wait ended");
	sys_tick_pulse_a: assert property (SYS_CLK_EN_OUT |=> !SYS_CLK_EN_OUT)
		else $error("tick wider than one cycle");
	reset_quiet_a: assert property ($fell(SYS_RST_IN) |-> !CLK_OUT_PIN_OUT && !IRQ_OUT && !LP_BOOST_OUT)
		else $error("output active after reset");
	boost_xtal_a: assert property (LP_BOOST_OUT |-> LP_XTAL_SEL_OUT)
		else $error("boost outside crystal mode");
endmodule // csg_top_monitor

bind csg_top csg_top_monitor csg_top_monitor_i (
	.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.FAST_OSC_EN_OUT(FAST_OSC_EN_OUT), .LP_XTAL_SEL_OUT(LP_XTAL_SEL_OUT), .LP_BOOST_OUT(LP_BOOST_OUT),
	.SYS_CLK_EN_OUT(SYS_CLK_EN_OUT), .CLK_OUT_PIN_OUT(CLK_OUT_PIN_OUT), .IRQ_OUT(IRQ_OUT)
);

// ### sim/csg_top_tb.sv
module csg_top_tb;
	import csg_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst, psel, pen, pwr, slp, lp_fail, ext_pres;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, fast_en, lp_en, hs_en, ext_en, xsel, boost;
	logic        sys_en, per_en, pin, irq, lpw, hsw, extw;
	int          n_fail, num_checks;
	csg_top #(.LP_INT_DIV(8), .LP_STOP_TO(64), .LP_WAIT_BASE(4), .HS_WAIT_BASE(4)) csg_top_i (
		.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .SLEEP_REQ_IN(slp), .LP_XTAL_IN(lpw), .HS_XTAL_IN(hsw),
		.EXT_CLK_IN(extw), .FAST_OSC_EN_OUT(fast_en), .LP_OSC_EN_OUT(lp_en), .HS_OSC_EN_OUT(hs_en),
		.EXT_CLK_EN_OUT(ext_en), .LP_XTAL_SEL_OUT(xsel), .LP_BOOST_OUT(boost), .SYS_CLK_EN_OUT(sys_en),
		.PER_CLK_EN_OUT(per_en), .CLK_OUT_PIN_OUT(pin), .IRQ_OUT(irq));
	csg_osc_model csg_osc_model_i (.lp_on_in(lp_en && !lp_fail), .hs_on_in(hs_en), .ext_on_in(ext_pres),
		.lp_wave_out(lpw), .hs_wave_out(hsw), .ext_wave_out(extw));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task final_report;
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tmo(input string nm);
		n_fail++;
		$display("CHECK FAILED %s expected event seen timeout", nm);
		final_report();
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			tmo("pready");
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(nm, x, r & m);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Spacing between the second and third tick seen
	task gap(input logic s, output int g);
		int i, n, t;
		n = 0;
		t = 0;
		for (i = 0; i < 9000 && n < 3; i++) begin
			@(posedge clk);
			if ((s ? per_en : sys_en) === 1'b1) begin
				n++;
				if (n == 2)
					t = i;
			end
		end
		if (n < 3)
			tmo("tick");
		g = i - 1 - t;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_boot;
		int g;
		gap(1'b0, g);
		chk("boot_gap", 32'd31, 32'(g));
		chk("fast_en", 32'd1, 32'(fast_en));
		rdc("src_en", OFS_SRC_EN, 32'h0000_003F, 32'h0000_0001);
		rdc("fast_cfg", OFS_FAST_CFG, 32'h0000_0007, 32'h0000_0003);
		rdc("status", OFS_STATUS, 32'h0000_00FF, 32'h0000_0011);
	endtask
	task t_freq;
		int per[8];
		int g, k;
		per = '{12, 15, 20, 31, 125, 250, 31, 31};
		for (k = 0; k < 8; k++) begin
			wr(OFS_FAST_CFG, 32'(k));
			gap(1'b0, g);
			chk("fast_gap", 32'(per[k]), 32'(g));
		end
		wr(OFS_FAST_CFG, 32'h0000_0003);
	endtask
	task t_div;
		int g;
		wr(OFS_SYS_CLK, 32'h0000_0008);
		gap(1'b0, g);
		chk("sys_div4", 32'd124, 32'(g));
		wr(OFS_SYS_CLK, 32'h0000_0000);
		ext_pres <= 1'b1;
		cyc(20);
		wr(OFS_SRC_EN, 32'h0000_0009);
		wr(OFS_PER_CLK, 32'h0000_0003);
		gap(1'b1, g);
		chk("per_ext", 32'd10, 32'(g));
		wr(OFS_PER_CLK, 32'h0000_000F);
		gap(1'b1, g);
		chk("per_ext_div8", 32'd80, 32'(g));
	endtask
	task t_irq;
		logic [31:0] r;
		logic        e;
		wr(OFS_INT_EN, 32'h0000_0001);
		cyc(3);
		chk("irq_on", 32'd1, 32'(irq));
		wr(OFS_INT_EN, 32'h0000_0000);
		cyc(3);
		chk("irq_masked", 32'd0, 32'(irq));
		wr(OFS_INT_EN, 32'h0000_0001);
		wr(OFS_INT_CLR, 32'h0000_0001);
		cyc(3);
		chk("irq_cleared", 32'd0, 32'(irq));
		rdc("int_stat", OFS_INT_STAT, 32'h0000_0001, 32'h0000_0000);
		wr(OFS_STATUS, 32'h0000_0000);
		rdc("status_ro", OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0000_0000, r, e);
		chk("unmapped_err", 32'd1, 32'(e));
		chk("unmapped_data", 32'h0000_0000, r);
		wr(OFS_WAIT, 32'h0000_0073);
		rdc("wait_cfg", OFS_WAIT, 32'h0000_007F, 32'h0000_0073);
		wr(OFS_WAIT, 32'h0000_0000);
	endtask
	task t_clkout;
		int   n, i;
		logic p;
		wr(OFS_CLK_OUT, 32'h0000_0001);
		n = 0;
		p = pin;
		for (i = 0; i < 310; i++) begin
			@(posedge clk);
			if (pin !== p)
				n++;
			p = pin;
		end
		chk("pin_toggles", 32'd1, 32'(n >= 9 && n <= 11));
		wr(OFS_CLK_OUT, 32'h0000_0000);
		cyc(3);
		chk("pin_low", 32'd0, 32'(pin));
	endtask
	task t_sleep;
		int g;
		wr(OFS_SLEEP, 32'h0000_4478);
		slp <= 1'b1;
		cyc(4);
		chk("sleep_ext_off", 32'd0, 32'(ext_en));
		chk("sleep_fast_on", 32'd1, 32'(fast_en));
		rdc("sleeping", OFS_STATUS, 32'h0000_0100, 32'h0000_0100);
		slp <= 1'b0;
		cyc(4);
		chk("wake_ext_kept", 32'd1, 32'(ext_en));
		chk("wake_hs_on", 32'd1, 32'(hs_en));
		rdc("wake_src", OFS_SYS_CLK, 32'h0000_0003, 32'h0000_0003);
		gap(1'b0, g);
		chk("wake_gap", 32'd10, 32'(g));
		wr(OFS_SYS_CLK, 32'h0000_0000);
	endtask
	task t_lp;
		int n;
		wr(OFS_SRC_EN, 32'h0000_003F);
		cyc(3);
		chk("xtal_sel", 32'd1, 32'(xsel));
		for (n = 0; n < 20 && boost !== 1'b1; n++)
			@(posedge clk);
		if (n == 20)
			tmo("boost_start");
		for (n = 0; n < 2000 && boost === 1'b1; n++)
			@(posedge clk);
		if (n == 2000)
			tmo("boost_end");
		chk("boost_len", 32'd1, 32'(n >= 500 && n <= 530));
		lp_fail <= 1'b1;
		for (n = 0; n < 600 && lp_en !== 1'b0; n++)
			@(posedge clk);
		if (n == 600)
			tmo("stop_detect");
		chk("stop_seen", 32'd0, 32'(lp_en));
		cyc(2);
		chk("restart", 32'd1, 32'(lp_en));
		lp_fail <= 1'b0;
		rdc("stop_flag", OFS_INT_STAT, 32'h0000_0010, 32'h0000_0010);
		wr(OFS_SRC_EN, 32'h0000_000F);
		cyc(3);
		chk("internal_sel", 32'd0, 32'(xsel));
	endtask
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		slp = 1'b0;
		lp_fail = 1'b0;
		ext_pres = 1'b0;
		n_fail = 0;
		num_checks = 0;
		cyc(6);
		rst <= 1'b0;
		t_boot();
		t_freq();
		t_div();
		t_irq();
		t_clkout();
		t_sleep();
		t_lp();
		final_report();
	end
endmodule // csg_top_tb
